// ===== src/scp_top.sv
// Two-wire serial control port: registers, master engine and slave engine
//
// The register offsets and the strobed register port are this design's own decisions.
module scp_top (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [scp_pkg::ADDR_W-1:0] ADDR,
  input wire logic [scp_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [scp_pkg::DATA_W-1:0] RDATA,
  input wire logic PIN_INPUT,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic PORT_ACTIVE,
  output logic PORT_IRQ
);
  import scp_pkg::*;

  // Control one fields
  logic write_collision_flag_q, ov_q, en_q, ckp_q;
  logic [3:0] mode_q;
  scp_ctrl2_t c2_q;
  // Status fields
  logic [1:0] cfg_q;
  logic da_q, stop_q, start_q, rw_q, ua_q, bf_q;
  logic [7:0] buf_q, sr_q, addr_q;
  logic irq_q;
  // Master engine
  scp_mstate_t mst_q;
  logic [1:0] ph_q;
  logic [3:0] bitn_q;
  logic [6:0] brg_q;
  logic m_scl_low_q, m_sda_low_q;
  // Slave engine
  logic scl_prev_q, sda_prev_q;
  logic s_act_q, s_adr_q, s_tx_q, s_ack_q, s_txbusy_q, s_nack_q;
  logic [3:0] s_cnt_q;
  logic scl_oe_q, sda_oe_q, active_q;
  logic [7:0] rdata_q;

  // Mode decode
  // (RULE5) listed codes only
  logic is_master, is_slave, is_i2c, ten_bit, ss_irq;
  assign is_master = en_q && (mode_q == MODE_MASTER);
  assign is_slave = en_q && (mode_q == MODE_SLV7 || mode_q == MODE_SLV10
                    || mode_q == MODE_SLV7_SS || mode_q == MODE_SLV10_SS);
  assign is_i2c = is_master || is_slave || (en_q && mode_q == MODE_FW_MASTER);
  assign ten_bit = mode_q[0];
  assign ss_irq = mode_q[3];

  // Register strobes
  logic wr_c1, wr_c2, wr_st, wr_buf, wr_adr, wr_evt, rd_buf;
  assign wr_c1 = WR && ADDR == OFS_CTRL1;
  assign wr_c2 = WR && ADDR == OFS_CTRL2;
  assign wr_st = WR && ADDR == OFS_STATUS;
  assign wr_buf = WR && ADDR == OFS_BUFFER;
  assign wr_adr = WR && ADDR == OFS_ADDRESS;
  assign wr_evt = WR && ADDR == OFS_EVENT;
  assign rd_buf = RD && ADDR == OFS_BUFFER;

  // Idle means engine stopped and nothing pending, so nothing queues
  logic port_idle, buf_load, tx_go, write_collision_flag_set;
  assign port_idle = mst_q == M_IDLE && c2_q[4:0] == 5'h00;
  // (RULE21) busy blocks writes
  assign buf_load = wr_buf && (is_master ? port_idle : !s_txbusy_q);
  assign tx_go = buf_load && is_master;
  // (RULE7) master write collision
  // (RULE8) slave write collision
  assign write_collision_flag_set = wr_buf && !buf_load;

  // Bus edges; inputs are already synchronous
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = SCL_I && !scl_prev_q;
  assign scl_fall = !SCL_I && scl_prev_q;
  assign start_det = scl_prev_q && SCL_I && sda_prev_q && !SDA_I;
  assign stop_det = scl_prev_q && SCL_I && !sda_prev_q && SDA_I;

  // Master timing; a slave holding SCL low stalls the generator
  logic stall, tick, m_last, m_ack_smp, m_rx_smp, m_tx_shift, m_rx_done;
  assign stall = !m_scl_low_q && !SCL_I;
  assign tick = is_master && mst_q != M_IDLE && brg_q == 7'h00 && !stall;
  assign m_last = tick && ph_q == PH_LAST && (mst_q == M_START
                  || mst_q == M_RSTART || mst_q == M_STOP || mst_q == M_ACK
                  || (mst_q == M_TX && bitn_q == ACK_SLOT)
                  || (mst_q == M_RX && bitn_q == BIT_LAST));
  assign m_ack_smp = tick && ph_q == PH_SAMPLE && mst_q == M_TX && bitn_q == ACK_SLOT;
  assign m_rx_smp = tick && ph_q == PH_SAMPLE && mst_q == M_RX;
  assign m_tx_shift = tick && ph_q == PH_LAST && mst_q == M_TX && bitn_q < ACK_SLOT;
  assign m_rx_done = m_last && mst_q == M_RX;

  // Slave byte evaluation on the eighth falling edge
  logic s_byte, s_match, s_load, s_ovf, s_ninth, s_smp, s_stretch;
  assign s_byte = is_slave && s_act_q && scl_fall && s_cnt_q == BIT_LAST;
  // (RULE12) general call only when enabled
  assign s_match = sr_q[7:1] == addr_q[7:1] || (c2_q.general_call_enable && sr_q == GENERAL_CALL);
  assign s_load = s_byte && !s_tx_q && (!s_adr_q || s_match) && !bf_q && !ov_q;
  assign s_ovf = s_byte && !s_tx_q && !s_adr_q && (bf_q || ov_q);
  assign s_ninth = is_slave && s_act_q && scl_fall && s_cnt_q == ACK_SLOT;
  assign s_smp = is_slave && s_act_q && scl_rise && s_cnt_q < ACK_SLOT && !s_tx_q;
  // (RULE20) stretch after receive only if enabled
  assign s_stretch = s_ninth && (rw_q || (c2_q.start_en && bf_q && !s_adr_q));

  // Register read port, data one cycle after the strobe
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
      rdata_q <= REG_RESET;
    else if (RD)
    begin
      case (ADDR)
        OFS_STATUS: rdata_q <= {cfg_q, da_q, stop_q, start_q, rw_q, ua_q, bf_q};
        OFS_CTRL1: rdata_q <= {write_collision_flag_q, ov_q, en_q, ckp_q, mode_q};
        OFS_CTRL2: rdata_q <= c2_q;
        OFS_BUFFER: rdata_q <= buf_q;
        OFS_ADDRESS: rdata_q <= addr_q;
        OFS_EVENT: rdata_q <= {7'h00, irq_q};
        default: rdata_q <= REG_RESET;
      endcase
    end
    else
      rdata_q <= REG_RESET;
  end

  // Control one; hardware sets beat software clears
  // (RULE26) reset zeroes control
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      write_collision_flag_q <= 1'b0;
      ov_q <= 1'b0;
      en_q <= 1'b0;
      ckp_q <= 1'b0;
      mode_q <= 4'h0;
    end
    else
    begin
      if (wr_c1)
      begin
        write_collision_flag_q <= WDATA[7];
        ov_q <= WDATA[6];
        en_q <= WDATA[5];
        ckp_q <= WDATA[4];
        mode_q <= WDATA[3:0];
      end
      if (write_collision_flag_set)
        write_collision_flag_q <= 1'b1;
      // (RULE9) overflow on full buffer
      if (s_ovf || (m_rx_done && bf_q))
        ov_q <= 1'b1;
      // (RULE11) hold SCL until released
      if (s_stretch)
        ckp_q <= 1'b0;
    end
  end

  // Control two; in master mode enable bits accepted only while idle, other modes always
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
      c2_q <= REG_RESET;
    else
    begin
      if (wr_c2)
      begin
        c2_q.general_call_enable <= WDATA[7];
        c2_q.ack_status <= WDATA[6];
        c2_q.ack_data <= WDATA[5];
        // (RULE21) refuse enables while busy
        if (!is_master || port_idle)
          c2_q[4:0] <= WDATA[4:0];
      end
      // (RULE13) latch slave acknowledge
      if (m_ack_smp)
        c2_q.ack_status <= SDA_I;
      // (RULE25) clear at sequence end
      if (m_last)
      begin
        case (mst_q)
          M_START: c2_q.start_en <= 1'b0;
          M_RSTART: c2_q.rstart_en <= 1'b0;
          M_STOP: c2_q.stop_en <= 1'b0;
          M_RX: c2_q.rx_en <= 1'b0;
          M_ACK: c2_q.ack_en <= 1'b0;
          default: c2_q.general_call_enable <= c2_q.general_call_enable;
        endcase
      end
    end
  end

  // Status, address and event registers
  // (RULE22) only top two bits writable
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      cfg_q <= 2'h0;
      addr_q <= REG_RESET;
      irq_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      ua_q <= 1'b0;
      da_q <= 1'b0;
    end
    else
    begin
      if (wr_st)
        cfg_q <= WDATA[7:6];
      // (RULE3) own address or reload value
      if (wr_adr)
        addr_q <= WDATA;
      if (wr_evt && WDATA[0])
        irq_q <= 1'b0;
      // (RULE2) flag set on completed byte
      if (m_last || s_ninth || (is_slave && ss_irq && (start_det || stop_det)))
        irq_q <= 1'b1;
      if (wr_adr)
        ua_q <= 1'b0;
      if (s_byte && s_adr_q && ten_bit && s_match)
        ua_q <= 1'b1;
      if (s_byte)
        da_q <= !s_adr_q;
      if (!en_q)
      begin
        start_q <= 1'b0;
        stop_q <= 1'b0;
      end
      else if (start_det || stop_det)
      begin
        start_q <= start_det;
        stop_q <= stop_det;
      end
    end
  end

  // Buffer, full flag and read/write indicator
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      buf_q <= REG_RESET;
      bf_q <= 1'b0;
      rw_q <= 1'b0;
    end
    else
    begin
      if (buf_load)
        buf_q <= WDATA;
      // (RULE2) double-buffered receive
      else if (s_load || (m_rx_done && !bf_q))
        buf_q <= sr_q;
      // (RULE24) read clears full, set wins
      if (rd_buf)
        bf_q <= 1'b0;
      if ((m_last && mst_q == M_TX) || (s_byte && s_tx_q))
        bf_q <= 1'b0;
      if (buf_load || s_load || (m_rx_done && !bf_q))
        bf_q <= 1'b1;
      if (is_master)
        rw_q <= mst_q != M_IDLE;
      else if (s_byte && s_adr_q && s_match)
        rw_q <= sr_q[0];
      else if (!s_act_q)
        rw_q <= 1'b0;
    end
  end

  // Shift register, shared by both engines and the buffer write
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
      sr_q <= REG_RESET;
    // (RULE1) write lands in shifter too
    else if (buf_load)
      sr_q <= WDATA;
    else if (m_tx_shift || (s_tx_q && s_txbusy_q && scl_fall && s_cnt_q < BIT_LAST))
      sr_q <= {sr_q[6:0], 1'b0};
    else if (m_rx_smp || s_smp)
      sr_q <= {sr_q[6:0], SDA_I};
  end

  // Bit-rate generator, one tick per quarter bit
  // (RULE4) quarter period is reload+1 cycles
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
      brg_q <= 7'h00;
    else if (!is_master || mst_q == M_IDLE || brg_q == 7'h00)
      brg_q <= stall && mst_q != M_IDLE ? brg_q : addr_q[6:0];
    else
      brg_q <= brg_q - 7'h01;
  end

  // Master sequencer; each bit takes four quarter ticks
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN || !is_master)
    begin
      mst_q <= M_IDLE;
      ph_q <= 2'h0;
      bitn_q <= 4'h0;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
    end
    else
    begin
      case (mst_q)
        M_IDLE:
        begin
          ph_q <= 2'h0;
          bitn_q <= 4'h0;
          // (RULE19) start condition
          if (c2_q.start_en)
            mst_q <= M_START;
          // (RULE18) repeated start
          else if (c2_q.rstart_en)
            mst_q <= M_RSTART;
          // (RULE17) stop condition
          else if (c2_q.stop_en)
            mst_q <= M_STOP;
          // (RULE16) receive one byte
          else if (c2_q.rx_en)
            mst_q <= M_RX;
          // (RULE15) acknowledge sequence
          else if (c2_q.ack_en)
            mst_q <= M_ACK;
          else if (tx_go)
            mst_q <= M_TX;
        end
        M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK:
        begin
          if (tick)
          begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0:
              begin
                m_sda_low_q <= mst_q == M_STOP
                  || (mst_q == M_TX && bitn_q < ACK_SLOT && !sr_q[7])
                  // (RULE14) ack level from ack data bit
                  || (mst_q == M_ACK && !c2_q.ack_data);
                if (mst_q == M_START)
                  m_scl_low_q <= 1'b0;
              end
              2'h1:
              begin
                if (mst_q == M_START)
                  m_sda_low_q <= 1'b1;
                else
                  m_scl_low_q <= 1'b0;
              end
              2'h2:
              begin
                if (mst_q == M_START)
                  m_scl_low_q <= 1'b1;
                else if (mst_q == M_RSTART)
                  m_sda_low_q <= 1'b1;
                else if (mst_q == M_STOP)
                  m_sda_low_q <= 1'b0;
              end
              default:
              begin
                if (mst_q != M_STOP)
                  m_scl_low_q <= 1'b1;
                bitn_q <= bitn_q + 4'h1;
                if (m_last)
                  mst_q <= M_IDLE;
              end
            endcase
          end
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // Slave engine follows SCL edges; disabled port abandons the transfer
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      s_act_q <= 1'b0;
      s_adr_q <= 1'b0;
      s_tx_q <= 1'b0;
      s_ack_q <= 1'b0;
      s_txbusy_q <= 1'b0;
      s_nack_q <= 1'b0;
      s_cnt_q <= 4'h0;
    end
    else
    begin
      scl_prev_q <= SCL_I;
      sda_prev_q <= SDA_I;
      if (buf_load && is_slave)
        s_txbusy_q <= 1'b1;
      if (!is_slave || stop_det)
      begin
        s_act_q <= 1'b0;
        s_tx_q <= 1'b0;
        s_ack_q <= 1'b0;
        s_txbusy_q <= 1'b0;
      end
      else if (start_det)
      begin
        s_act_q <= 1'b1;
        s_adr_q <= 1'b1;
        s_tx_q <= 1'b0;
        s_cnt_q <= 4'h0;
      end
      else if (s_act_q)
      begin
        if (scl_rise && s_cnt_q == ACK_SLOT && s_tx_q)
          s_nack_q <= SDA_I;
        if (scl_fall)
          s_cnt_q <= s_cnt_q + 4'h1;
        if (s_byte)
        begin
          if (s_tx_q)
            s_txbusy_q <= 1'b0;
          else if (s_adr_q && !s_match)
            s_act_q <= 1'b0;
          else
            s_ack_q <= !bf_q && !ov_q;
          s_adr_q <= 1'b0;
        end
        if (s_ninth)
        begin
          s_cnt_q <= 4'h0;
          s_ack_q <= 1'b0;
          s_tx_q <= rw_q;
          if (s_tx_q && s_nack_q)
            s_act_q <= 1'b0;
        end
      end
    end
  end

  // Pin drive, registered; the port only ever pulls low
  // (RULE10) enable assigns the pins
  // (RULE23) open-drain only when pins are inputs
  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      active_q <= 1'b0;
    end
    else
    begin
      active_q <= is_i2c;
      // (RULE11) clock release only in slave mode
      scl_oe_q <= is_i2c && PIN_INPUT && (is_master ? m_scl_low_q : is_slave && !ckp_q);
      sda_oe_q <= is_i2c && PIN_INPUT && (is_master ? m_sda_low_q
                  : s_ack_q || (s_tx_q && s_txbusy_q && !sr_q[7]));
    end
  end

  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = scl_oe_q;
  assign SDA_OE = sda_oe_q;
  assign PORT_ACTIVE = active_q;
  assign PORT_IRQ = irq_q;
  assign RDATA = rdata_q;
endmodule

// ===== src/scp_pkg.sv
// Constants, field layouts and types of the two-wire serial control port
// Functional notes
// (RULE1) Buffer write loads shift register too
// (RULE2) Received byte moves to buffer, flag set
// (RULE3) Address register: own address or reload
// (RULE4) Master clock is osc/(4*(reload+1))
// (RULE5) Mode field decodes slave/master variants
// (RULE6) Software avoids unlisted mode codes
// (RULE7) Master buffer write refused sets collision
// (RULE8) Slave write during shifting sets collision
// (RULE9) Byte into full buffer sets overflow
// (RULE10) Enable bit hands pins to port
// (RULE11) Slave clock release bit frees SCL
// (RULE12) General call interrupts only when enabled
// (RULE13) Ack status shows slave acknowledge
// (RULE14) Ack data bit gives sent level
// (RULE15) Ack enable sends ack, self-clears
// (RULE16) Receive enable clocks in one byte
// (RULE17) Stop enable sends STOP, self-clears
// (RULE18) Repeated-start enable sends it, self-clears
// (RULE19) Start enable sends START, self-clears
// (RULE20) Slave stretch bit covers receive too
// (RULE21) Busy port refuses enables and writes
// (RULE22) Status low six bits read-only
// (RULE23) Enabled mode drives pins open-drain
// (RULE24) Buffer read clears full flag
// (RULE25) Enable bits clear at sequence end
// (RULE26) Reset zeroes all control registers
package scp_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] OFS_STATUS = 3'h0;
  localparam logic [2:0] OFS_CTRL1 = 3'h1;
  localparam logic [2:0] OFS_CTRL2 = 3'h2;
  localparam logic [2:0] OFS_BUFFER = 3'h3;
  localparam logic [2:0] OFS_ADDRESS = 3'h4;
  localparam logic [2:0] OFS_EVENT = 3'h5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_SLV7_SS = 4'he;
  localparam logic [3:0] MODE_SLV10_SS = 4'hf;
  localparam logic [7:0] GENERAL_CALL = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  typedef struct packed {
    logic general_call_enable;
    logic ack_status;
    logic ack_data;
    logic ack_en;
    logic rx_en;
    logic stop_en;
    logic rstart_en;
    logic start_en;
  } scp_ctrl2_t;
  typedef enum logic [6:0] {
    M_IDLE = 7'b0000001,
    M_START = 7'b0000010,
    M_RSTART = 7'b0000100,
    M_STOP = 7'b0001000,
    M_TX = 7'b0010000,
    M_RX = 7'b0100000,
    M_ACK = 7'b1000000
  } scp_mstate_t;
endpackage

// ===== dv/scp_sva.sv
// Checker of register bus and pin relations of the serial control port
module scp_sva (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [scp_pkg::ADDR_W-1:0] ADDR,
  input wire logic [scp_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [scp_pkg::DATA_W-1:0] RDATA,
  input wire logic PIN_INPUT,
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic PORT_ACTIVE,
  input wire logic PORT_IRQ
);
  import scp_pkg::*;
  // One clock domain, so one default clocking and reset
  default clocking dc @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  // Codes that hand the pins to the port
  function automatic logic is_i2c(input logic [3:0] m);
    return m inside {MODE_MASTER, MODE_FW_MASTER, MODE_SLV7, MODE_SLV10, MODE_SLV7_SS,
      MODE_SLV10_SS};
  endfunction

  a_reset_clear: assert property (
    $rose(RESETN) |-> RDATA == 8'h00 && !PORT_ACTIVE && !PORT_IRQ && !SCL_OE && !SDA_OE)
    else $error("state not cleared by reset");
  a_od_const: assert property (
    SCL_O == 1'b0 && SDA_O == 1'b0)
    else $error("pin driven high");
  a_pins_released: assert property (
    !PORT_ACTIVE [*2] |-> !SCL_OE && !SDA_OE)
    else $error("pins driven while port off");
  a_dir_gate: assert property (
    !PIN_INPUT [*2] |-> !SCL_OE && !SDA_OE)
    else $error("pins driven while not inputs");
  // Two idle cycles after the write so the level has settled
  a_active_mode: assert property (
    (WR && ADDR == OFS_CTRL1) ##1 !WR ##1 !WR |=>
      PORT_ACTIVE == (is_i2c($past(WDATA[3:0], 3)) && $past(WDATA[5], 3)))
    else $error("active level does not match mode");
  a_irq_sticky: assert property (
    PORT_IRQ && !(WR && ADDR == OFS_EVENT && WDATA[0]) |=> PORT_IRQ)
    else $error("interrupt flag dropped by itself");
  a_stat_cfg: assert property (
    (WR && ADDR == OFS_STATUS) ##1 (RD && ADDR == OFS_STATUS) |=>
      RDATA[7:6] == $past(WDATA[7:6], 2))
    else $error("status config bits not kept");
  a_ctrl_readback: assert property (
    (WR && ADDR == OFS_CTRL1) ##1 (RD && ADDR == OFS_CTRL1) |=>
      RDATA[5] == $past(WDATA[5], 2) && RDATA[3:0] == $past(WDATA[3:0], 2))
    else $error("control bits not kept");
endmodule

bind scp_top scp_sva u_sva (.SYS_CLK, .RESETN, .ADDR, .WDATA, .WR, .RD, .RDATA, .PIN_INPUT,
  .SCL_I, .SCL_O, .SCL_OE, .SDA_I, .SDA_O, .SDA_OE, .PORT_ACTIVE, .PORT_IRQ);

// ===== dv/scp_bus_model.sv
// Two-wire slave on the bus: acks its address, takes and sends bytes
module scp_bus_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic refuse,
  input wire logic [7:0] tx_byte,
  output logic sda_low,
  output logic [7:0] rx_byte,
  output logic got_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic on_q = 1'b0;
  logic first_q = 1'b0;
  logic rd_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] sh_q = 8'h00;
  logic [7:0] out_q = 8'h00;
  logic [7:0] nxt_q = 8'h00;
  logic [7:0] next_b;
  // Each further byte counts up so a dropped one is visible
  assign next_b = first_q ? tx_byte : nxt_q;
  initial
  begin
    sda_low = 1'b0;
    rx_byte = 8'h00;
    got_ack = 1'b0;
  end
  // Edge tracking; count starts at f to skip the fall after START
  always @(posedge clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda)
    begin
      on_q <= 1'b1;
      first_q <= 1'b1;
      rd_q <= 1'b0;
      cnt_q <= 4'hf;
      sda_low <= 1'b0;
    end
    else if (scl && scl_q && !sda_q && sda)
    begin
      on_q <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (on_q && scl && !scl_q)
    begin
      if (cnt_q < 4'h8)
        sh_q <= {sh_q[6:0], sda};
      else if (rd_q)
        got_ack <= !sda;
    end
    else if (on_q && !scl && scl_q)
    begin
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h7)
        sda_low <= !rd_q && !refuse && (!first_q || sh_q[7:1] == DEV_ADDR);
      else if (cnt_q == 4'h8)
      begin
        first_q <= 1'b0;
        if (first_q ? sh_q[0] && sh_q[7:1] == DEV_ADDR : rd_q && got_ack)
        begin
          rd_q <= 1'b1;
          out_q <= next_b;
          nxt_q <= next_b + 8'h01;
          sda_low <= !next_b[7];
        end
        else
        begin
          rd_q <= 1'b0;
          sda_low <= 1'b0;
          rx_byte <= sh_q;
        end
      end
      else if (rd_q && cnt_q < 4'h7)
      begin
        out_q <= out_q << 1;
        sda_low <= !out_q[6];
      end
    end
  end
endmodule

// ===== dv/scp_top_test.sv
// Self-checking bench of the serial control port in master mode
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module scp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import scp_pkg::*;
  localparam logic [7:0] RELOAD = 8'h83; // Bit 7 must not touch the rate
  localparam int PERIOD = 16;
  localparam logic [6:0] DEV = 7'h2a;
  localparam logic [7:0] TXB = 8'hc5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd = 1'b0;
  logic pin_in = 1'b0;
  logic refuse = 1'b0;
  logic [7:0] rdata, rx_byte, q;
  logic scl_o, scl_oe, sda_o, sda_oe, active, irq, sda_low, got_ack, scl_w, sda_w;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  // Wired-AND with pull-ups
  assign scl_w = !scl_oe;
  assign sda_w = !sda_oe && !sda_low;
  scp_top dut (.SYS_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd),
    .RDATA(rdata), .PIN_INPUT(pin_in), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe), .PORT_ACTIVE(active), .PORT_IRQ(irq));
  scp_bus_model #(.DEV_ADDR(DEV)) peer (.clk(clk), .scl(scl_w), .sda(sda_w), .refuse(refuse),
    .tx_byte(TXB), .sda_low(sda_low), .rx_byte(rx_byte), .got_ack(got_ack));

  task complete_run;
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Bus cycles: one-cycle strobes, read data in the following cycle
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  // Write then read back with no gap
  task wrrd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task check_reg(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    `CHK(v, e)
  endtask
  // Sequence end raises the flag; clear it for the next one
  task seq(input logic [2:0] a, input logic [7:0] d);
    int n;
    if (a != OFS_EVENT)
      wr(a, d);
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(irq, 1'b1)
    wr(OFS_EVENT, 8'h01);
    // Partner sees the last SCL fall two edges late; let it land
    @(negedge clk);
  endtask

  task t_reset_regs;
    for (int i = 0; i < 8; i++)
      check_reg(3'(i), 8'h00);
    wr(3'h6, 8'hff);
    check_reg(3'h6, 8'h00);
    wrrd(OFS_STATUS, 8'hff, q);
    `CHK(q, 8'hc0)
    wr(OFS_STATUS, 8'h00);
  endtask
  task t_modes;
    logic exp;
    for (int m = 0; m < 16; m++)
    begin
      wrrd(OFS_CTRL1, {4'h2, 4'(m)}, q);
      @(negedge clk);
      exp = 4'(m) inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
      `CHK(q, {4'h2, 4'(m)})
      `CHK(active, exp)
    end
    wr(OFS_CTRL1, 8'h08);
    repeat (2) @(negedge clk);
    `CHK(active, 1'b0)
  endtask
  // Busy port refuses new enables and buffer writes
  task t_start_busy;
    @(posedge clk);
    pin_in <= 1'b1;
    wr(OFS_ADDRESS, RELOAD);
    wr(OFS_CTRL1, 8'h28);
    wr(OFS_CTRL2, 8'h01);
    wr(OFS_CTRL2, 8'h05);
    wr(OFS_BUFFER, 8'h99);
    check_reg(OFS_CTRL2, 8'h01);
    seq(OFS_EVENT, 8'h00);
    check_reg(OFS_CTRL2, 8'h00);
    check_reg(OFS_CTRL1, 8'ha8);
    wr(OFS_CTRL1, 8'h28);
    check_reg(OFS_CTRL1, 8'h28);
  endtask
  task t_write;
    int n;
    wr(OFS_BUFFER, {DEV, 1'b0});
    wait (!scl_oe);
    wait (scl_oe);
    // Start on a negedge so no edge is counted twice
    @(negedge clk);
    n = 0;
    while (scl_oe)
    begin
      @(negedge clk);
      n++;
    end
    while (!scl_oe)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, PERIOD)
    seq(OFS_EVENT, 8'h00);
    `CHK(rx_byte, {DEV, 1'b0})
    check_reg(OFS_CTRL2, 8'h00);
    seq(OFS_BUFFER, 8'h5c);
    `CHK(rx_byte, 8'h5c)
    seq(OFS_CTRL2, 8'h04);
    check_reg(OFS_CTRL2, 8'h00);
    @(posedge clk);
    refuse <= 1'b1;
    seq(OFS_CTRL2, 8'h01);
    seq(OFS_BUFFER, {DEV, 1'b0});
    check_reg(OFS_CTRL2, 8'h40);
    seq(OFS_CTRL2, 8'h04);
    refuse <= 1'b0;
  endtask
  // Second byte lands on an unread buffer
  task t_read;
    seq(OFS_CTRL2, 8'h01);
    seq(OFS_BUFFER, {DEV, 1'b1});
    seq(OFS_CTRL2, 8'h08);
    check_reg(OFS_CTRL2, 8'h00);
    seq(OFS_CTRL2, 8'h10);
    `CHK(got_ack, 1'b1)
    seq(OFS_CTRL2, 8'h08);
    check_reg(OFS_CTRL1, 8'h68);
    check_reg(OFS_BUFFER, TXB);
    rd_reg(OFS_STATUS, q);
    `CHK(q[0], 1'b0)
    wr(OFS_CTRL1, 8'h28);
    check_reg(OFS_CTRL1, 8'h28);
    seq(OFS_CTRL2, 8'h30);
    `CHK(got_ack, 1'b0)
    check_reg(OFS_CTRL2, 8'h20);
    seq(OFS_CTRL2, 8'h22);
    check_reg(OFS_CTRL2, 8'h20);
    seq(OFS_CTRL2, 8'h24);
  endtask
  task t_mid_reset;
    seq(OFS_CTRL2, 8'h01);
    wr(OFS_BUFFER, 8'h3c);
    repeat (40) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    check_reg(OFS_CTRL1, 8'h00);
    check_reg(OFS_CTRL2, 8'h00);
    `CHK(sda_oe, 1'b0)
  endtask

  // Main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_modes();
    t_start_busy();
    t_write();
    t_read();
    t_mid_reset();
    complete_run();
  end
  // Run is far shorter than this; a hang ends here
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
endmodule
